/* File: hw/rtcsa_defines.svh */
// ============================================================
// Behaviour
// - pointer read: write address, restart, read
// - pointer advances on master ack only
// - stream next locations until STOP
// - clock address read freezes time copy
// - freeze ends on STOP or RAM address
// - bare read starts at stored pointer
// - write: address byte loads the pointer
// - data stored at pointer, then pointer advances
// - ack address, word address, each data byte while the write buffer has room
// - power fail deselects and write protects
// - power fail asserts reset output
// - protection and reset hold for recovery delay
// - on battery all outputs released
// - battery check at power-up and daily
// - low battery sets flag bit four
// - flag stays until a later check passes
// - no battery check without main supply
// - answer only the fixed slave address
// - power fail aborts transfer, clears pointer
`ifndef RTCSA_DEFINES_SVH
`define RTCSA_DEFINES_SVH

`define RTCSA_SLAVE7      7'h68
`define RTCSA_CLK_END     6'h07
`define RTCSA_RAM_BASE    6'h14
`define RTCSA_FLAGS_ADDR  6'h0F
`define RTCSA_FLAGS_RST   8'h00
`define RTCSA_BL_BIT      4
`define RTCSA_PTR_ZERO    6'h00
`define RTCSA_PTR_LAST    6'h3F
`define RTCSA_BITS        4'h8
`define RTCSA_LAST_BIT    4'h7
`define RTCSA_CLK_NS      4
`define RTCSA_REC_TIME_US 40
`define RTCSA_DAY_TICKS   86400

`endif

/* File: hw/rtcsa_pkg.sv */
package rtcsa_pkg;
  // ============================================================
  // serial engine states, one-hot
  typedef enum logic [4:0]
  {
    RTCSA_IDLE = 5'h01,
    RTCSA_RX   = 5'h02,
    RTCSA_ACK  = 5'h04,
    RTCSA_TX   = 5'h08,
    RTCSA_MACK = 5'h10
  } rtcsa_state_e;

  // which byte of a write-direction transfer is being received
  typedef enum logic [1:0]
  {
    RTCSA_K_ADDR  = 2'h0,
    RTCSA_K_WADDR = 2'h1,
    RTCSA_K_DATA  = 2'h2
  } rtcsa_kind_e;

  // one buffered register write
  typedef struct packed
  {
    logic [5:0] addr;
    logic [7:0] data;
  } rtcsa_wr_s;
endpackage

/* File: hw/rtcsa_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rtcsa_defines.svh"

// ============================================================
// write buffer between serial receiver and register array
module rtcsa_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output var  logic         o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output var  logic         o_out_valid,
  input  wire logic         i_out_ready,
  output var  logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  wire push = i_in_valid && o_in_ready;
  wire pop  = o_out_valid && i_out_ready;

  // honest full and empty from the occupancy count
  assign o_in_ready  = (cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt != '0);
  assign o_out_data  = mem[rp];

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wp] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ============================================================
// serial slave access and supply supervisor
module rtcsa_top #(
  parameter int REC_CYCLES = ((`RTCSA_REC_TIME_US * 1000) + `RTCSA_CLK_NS - 1) / `RTCSA_CLK_NS,
  parameter int DAY_TICKS  = `RTCSA_DAY_TICKS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda_i,
  output var  logic o_sda_o,
  output var  logic o_sda_oe,
  input  wire logic i_power_fail,
  input  wire logic i_on_battery,
  input  wire logic i_battery_below,
  input  wire logic i_tick,
  output var  logic o_rst_o,
  output var  logic o_rst_oe,
  output var  logic o_update_hold,
  output var  logic o_battery_low_flag
);
  // pointer step with wrap at the top of the 64 locations
  function automatic logic [5:0] ptr_next(input logic [5:0] p);
    ptr_next = (p == `RTCSA_PTR_LAST) ? `RTCSA_PTR_ZERO : p + 6'h01;
  endfunction

  // ==========================================================
  // input synchronisers; stage one feeds stage two only
  logic [4:0] sy1;
  logic [4:0] sy2;
  logic [1:0] sy3;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sy1 <= 5'h1B;
      sy2 <= 5'h1B;
      sy3 <= 2'h3;
    end
    else
    begin
      sy1 <= {i_scl, i_sda_i, i_power_fail, i_on_battery, i_battery_below};
      sy2 <= sy1;
      sy3 <= sy2[4:3];
    end
  end
  // reset values assume idle bus and failed supply until seen otherwise
  wire scl_s  = sy2[4];
  wire sda_s  = sy2[3];
  wire pf_s   = sy2[2] | sy2[1];
  wire bat_s  = sy2[1];
  wire blow_s = sy2[0];
  wire scl_rise = scl_s && !sy3[1];
  wire scl_fall = !scl_s && sy3[1];
  wire start    = scl_s && sy3[1] && !sda_s && sy3[0];
  wire stop     = scl_s && sy3[1] && sda_s && !sy3[0];

  // ==========================================================
  // supply supervisor: protection, reset pin, battery checks
  logic [23:0] rec;
  logic [23:0] day;
  wire wp       = pf_s || (rec != 24'h0);
  wire pwr_chk  = (rec == 24'h1) && !pf_s;
  wire day_end  = (day == 24'(DAY_TICKS - 1));
  wire day_chk  = i_tick && day_end && !wp;
  wire chk      = !pf_s && (pwr_chk || day_chk);

  // recovery count restarts on every power fail and at power-up
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rec  <= 24'(REC_CYCLES);
      day  <= 24'h0;
      o_battery_low_flag <= 1'b0;
      o_rst_o  <= 1'b0;
      o_rst_oe <= 1'b0;
    end
    else
    begin
      rec <= pf_s ? 24'(REC_CYCLES) : ((rec != 24'h0) ? rec - 24'h1 : rec);
      day <= wp ? 24'h0 : (i_tick ? (day_end ? 24'h0 : day + 24'h1) : day);
      if (chk)
        o_battery_low_flag <= blow_s;
      o_rst_o  <= 1'b0;
      o_rst_oe <= wp && !bat_s;
    end
  end

  // ==========================================================
  // register array and write buffer
  logic [7:0] regs [64];
  logic [5:0] ptr;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       rw;
  logic       acked;
  rtcsa_pkg::rtcsa_state_e st;
  rtcsa_pkg::rtcsa_kind_e  kind;
  rtcsa_pkg::rtcsa_wr_s    f_in;
  rtcsa_pkg::rtcsa_wr_s    f_out;
  logic f_in_ready;
  logic f_out_valid;

  wire byte_end = (st == rtcsa_pkg::RTCSA_RX) && scl_fall && (cnt == `RTCSA_BITS);
  wire tx_load  = scl_fall && (((st == rtcsa_pkg::RTCSA_ACK) && rw)
                  || ((st == rtcsa_pkg::RTCSA_MACK) && acked));
  wire busy_ev  = pf_s || bat_s || start || stop;
  wire f_push   = byte_end && (kind == rtcsa_pkg::RTCSA_K_DATA) && f_in_ready && !busy_ev;
  wire f_pop_ok = !tx_load; // drain stalls while a byte is fetched
  wire reg_we   = f_out_valid && f_pop_ok && !wp
                  && (f_out.addr != `RTCSA_FLAGS_ADDR);
  wire addr_hit = (sh[7:1] == `RTCSA_SLAVE7) && !wp;
  wire rx_ok    = (kind == rtcsa_pkg::RTCSA_K_ADDR) ? addr_hit
                : (kind == rtcsa_pkg::RTCSA_K_WADDR) ? 1'b1 : f_in_ready;
  wire [7:0] flags_rd = `RTCSA_FLAGS_RST | (8'h01 << `RTCSA_BL_BIT);
  wire [7:0] rd_data  = (ptr == `RTCSA_FLAGS_ADDR)
                      ? (o_battery_low_flag ? flags_rd : `RTCSA_FLAGS_RST) : regs[ptr];

  assign f_in.addr = ptr;
  assign f_in.data = sh;

  rtcsa_fifo #(.W(14), .DEPTH(8)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (f_push),
    .o_in_ready  (f_in_ready),
    .i_in_data   (f_in),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_pop_ok),
    .o_out_data  (f_out)
  );

  // contents are kept across power fail, so no reset here
  always_ff @(posedge i_clk)
  begin
    if (reg_we)
      regs[f_out.addr] <= f_out.data;
  end

  // ==========================================================
  // serial engine: sample on scl rise, drive on scl fall
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= rtcsa_pkg::RTCSA_IDLE;
      kind <= rtcsa_pkg::RTCSA_K_ADDR;
      ptr <= `RTCSA_PTR_ZERO;
      sh <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      acked <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (pf_s)
    begin
      st <= rtcsa_pkg::RTCSA_IDLE;
      ptr <= `RTCSA_PTR_ZERO;
      o_sda_oe <= 1'b0;
    end
    else if (start)
    begin
      st <= rtcsa_pkg::RTCSA_RX;
      kind <= rtcsa_pkg::RTCSA_K_ADDR;
      cnt <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else if (stop)
    begin
      st <= rtcsa_pkg::RTCSA_IDLE;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      case (st)
        rtcsa_pkg::RTCSA_RX:
        begin
          if (scl_rise)
          begin
            sh <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          else if (byte_end)
          begin
            cnt <= 4'h0;
            o_sda_oe <= rx_ok;
            st <= rx_ok ? rtcsa_pkg::RTCSA_ACK : rtcsa_pkg::RTCSA_IDLE;
            if (kind == rtcsa_pkg::RTCSA_K_ADDR)
              rw <= sh[0];
            if (kind == rtcsa_pkg::RTCSA_K_WADDR)
              ptr <= sh[5:0];
          end
        end
        rtcsa_pkg::RTCSA_ACK:
        begin
          if (scl_fall)
          begin
            if (!rw && (kind == rtcsa_pkg::RTCSA_K_DATA))
              ptr <= ptr_next(ptr);
            kind <= (kind == rtcsa_pkg::RTCSA_K_ADDR)
                    ? rtcsa_pkg::RTCSA_K_WADDR : rtcsa_pkg::RTCSA_K_DATA;
            st <= rw ? rtcsa_pkg::RTCSA_TX : rtcsa_pkg::RTCSA_RX;
            sh <= rw ? rd_data : sh;
            o_sda_oe <= rw && !rd_data[7];
          end
        end
        rtcsa_pkg::RTCSA_TX:
        begin
          if (scl_fall && (cnt == `RTCSA_LAST_BIT))
          begin
            o_sda_oe <= 1'b0; // free the line for the master ack
            cnt <= 4'h0;
            st <= rtcsa_pkg::RTCSA_MACK;
          end
          else if (scl_fall)
          begin
            cnt <= cnt + 4'h1;
            sh <= {sh[6:0], 1'b0};
            o_sda_oe <= !sh[6];
          end
        end
        rtcsa_pkg::RTCSA_MACK:
        begin
          if (scl_rise)
          begin
            acked <= !sda_s;
            if (!sda_s)
              ptr <= ptr_next(ptr);
          end
          else if (scl_fall)
          begin
            st <= acked ? rtcsa_pkg::RTCSA_TX : rtcsa_pkg::RTCSA_IDLE;
            sh <= rd_data;
            o_sda_oe <= acked && !rd_data[7];
          end
        end
        default:
          st <= rtcsa_pkg::RTCSA_IDLE;
      endcase
    end
  end

  // ==========================================================
  // time copy freeze while clock addresses are read out
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_update_hold <= 1'b0;
      o_sda_o <= 1'b0;
    end
    else
    begin
      o_sda_o <= 1'b0; // open drain: only the enable moves
      if (pf_s || stop)
        o_update_hold <= 1'b0;
      else if (tx_load && (ptr <= `RTCSA_CLK_END))
        o_update_hold <= 1'b1;
      else if (tx_load && (ptr >= `RTCSA_RAM_BASE))
        o_update_hold <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  chk_ack_advance: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st == rtcsa_pkg::RTCSA_MACK) && scl_rise && !sda_s && !busy_ev
    |=> ptr == ptr_next($past(ptr)))
    else $error("pointer did not advance on master ack");
  chk_nack_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st == rtcsa_pkg::RTCSA_MACK) && scl_rise && sda_s && !busy_ev |=> $stable(ptr))
    else $error("pointer moved without master ack");
  chk_hold_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tx_load && (ptr <= `RTCSA_CLK_END) && !busy_ev |=> o_update_hold)
    else $error("clock read did not freeze update");
  chk_hold_stop: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    stop |=> !o_update_hold)
    else $error("update freeze survived stop");
  chk_pf_abort: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pf_s |=> (st == rtcsa_pkg::RTCSA_IDLE) && (ptr == `RTCSA_PTR_ZERO) && !o_sda_oe)
    else $error("power fail did not abort transfer");
  chk_rst_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(pf_s) && !bat_s |=> o_rst_oe [*8])
    else $error("reset released before recovery delay");
  chk_rst_pf: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pf_s && !bat_s |=> o_rst_oe)
    else $error("reset not asserted in power fail");
  chk_batt_hiz: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bat_s |=> !o_sda_oe && !o_rst_oe)
    else $error("output driven on battery");
  chk_bl_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    chk |=> o_battery_low_flag == $past(blow_s))
    else $error("battery flag does not follow check");
  chk_no_check: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pf_s |-> !chk)
    else $error("battery check without main supply");
  chk_addr_ack: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_end && (kind == rtcsa_pkg::RTCSA_K_ADDR) && addr_hit && !busy_ev |=> o_sda_oe)
    else $error("own address not acknowledged");
  cov_read_stream: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    (st == rtcsa_pkg::RTCSA_MACK) && scl_rise && !sda_s);
  cov_write_byte: cover property (@(posedge i_clk) disable iff (!i_rst_n) f_push);
  cov_fifo_full: cover property (@(posedge i_clk) disable iff (!i_rst_n) !f_in_ready);
  cov_day_check: cover property (@(posedge i_clk) disable iff (!i_rst_n) day_chk);
endmodule

`default_nettype wire

/* File: verif/rtc_serial_access_supervisor_bench.sv */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// bench for the serial access and supply supervisor
module rtc_serial_access_supervisor_bench;
  localparam int REC = 20;
  localparam int DAY = 5;

  typedef struct packed
  {
    logic [5:0] addr;
    logic [7:0] data;
    logic       hold;
  } rtcsa_row_s;

  logic       clk = 1'h0;
  logic       rst_n;
  logic       scl;
  logic       sda;
  logic       sda_pull;
  logic       sda_oe;
  logic       pfail;
  logic       on_bat;
  logic       bat_low;
  logic       tick;
  logic       rst_oe;
  logic       hold;
  logic       flag;
  logic [8:0] r;
  int         bad_count = 0;
  int         check_count = 0;
  rtcsa_row_s rows [5] = '{'{6'h00, 8'hA5, 1'h1}, '{6'h07, 8'h3C, 1'h1},
    '{6'h08, 8'h5A, 1'h0}, '{6'h14, 8'hC3, 1'h0}, '{6'h3F, 8'h0F, 1'h0}};

  // open-drain data line with its pull-up
  assign sda = (sda_pull | sda_oe) ? 1'h0 : 1'h1;

  always #2 clk = ~clk;

  rtcsa_top #(.REC_CYCLES (REC), .DAY_TICKS (DAY)) i_dut (
    .i_clk (clk), .i_rst_n (rst_n), .i_scl (scl), .i_sda_i (sda),
    .o_sda_o (), .o_sda_oe (sda_oe), .i_power_fail (pfail), .i_on_battery (on_bat),
    .i_battery_below (bat_low), .i_tick (tick), .o_rst_o (), .o_rst_oe (rst_oe),
    .o_update_hold (hold), .o_battery_low_flag (flag));

  rtcsa_master i_master (.i_clk (clk), .i_sda (sda), .o_scl (scl), .o_sda_pull (sda_pull));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // byte the device must acknowledge
  task automatic send(input logic [7:0] b);
    i_master.xbyte({b, 1'h1}, r);
    check(8'(r[0]), 8'h00);
  endtask

  // read one byte into r[8:1], acknowledging it or not
  task automatic get(input logic ack);
    i_master.xbyte({8'hFF, !ack}, r);
  endtask

  task automatic point(input logic [5:0] a, input logic rd);
    i_master.start();
    send(8'hD0);
    send({2'h0, a});
    if (rd)
    begin
      i_master.start();
      send(8'hD1);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    point(a, 1'h0);
    send(d);
    i_master.stop();
  endtask

  // bounded wait for the reset pin to rise, then to let go; a hang ends the run
  task automatic wait_rst();
    int n;
    int w;
    n = 0;
    w = 0;
    // after power-up the pin only rises once the supply is seen through the synchroniser
    while (rst_oe !== 1'h1 && w < 8)
    begin
      @(posedge clk);
      #1;
      w++;
    end
    while (rst_oe === 1'h1 && n < 500)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(n >= REC && n <= REC + 8), 8'h01);
    if (n >= 500)
      results();
  endtask

  // timebase pulses, then room for the flag to settle
  task automatic ticks(input int n);
    repeat (n)
    begin
      tick = 1'h1;
      @(posedge clk);
      #1;
      tick = 1'h0;
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ============================================================
  // main sequence
  initial
  begin
    rst_n = 1'h0;
    pfail = 1'h0;
    on_bat = 1'h0;
    bat_low = 1'h0;
    tick = 1'h0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'h1;
    wait_rst();
    check(8'(flag), 8'h00);
    // table rows: write, read back, freeze seen mid-read for clock rows only and gone after stop
    for (int k = 0; k < 5; k++)
    begin
      wr(rows[k].addr, rows[k].data);
      point(rows[k].addr, 1'h1);
      get(1'h0);
      check(r[8:1], rows[k].data);
      check(8'(hold), 8'(rows[k].hold));
      i_master.stop();
      i_master.q();
      check(8'(hold), 8'h00);
    end
    // slow master: write across the top of the map, read back, bare read
    i_master.slow = 8;
    wr(6'h3F, 8'h11);
    point(6'h3F, 1'h0);
    send(8'h11);
    send(8'h22);
    i_master.stop();
    point(6'h3F, 1'h1);
    get(1'h1);
    check(r[8:1], 8'h11);
    get(1'h0);
    check(r[8:1], 8'h22);
    i_master.stop();
    i_master.start();
    send(8'hD1);
    get(1'h0);
    check(r[8:1], 8'h22);
    i_master.stop();
    i_master.slow = 0;
    // freeze holds over control bytes and ends at the first ram byte
    point(6'h07, 1'h1);
    for (int k = 0; k < 12; k++)
      get(1'h1);
    check(8'(hold), 8'h01);
    get(1'h1);
    i_master.q();
    check(8'(hold), 8'h00);
    get(1'h0);
    i_master.stop();
    // foreign address is ignored
    i_master.start();
    i_master.xbyte({8'hA0, 1'h1}, r);
    check(8'(r[0]), 8'h01);
    i_master.stop();
    // battery flag: set by the daily check, read only, cleared by a later pass
    bat_low = 1'h1;
    ticks(DAY);
    check(8'(flag), 8'h01);
    wr(6'h0F, 8'h00);
    point(6'h0F, 1'h1);
    get(1'h0);
    check(r[8:1], 8'h10);
    i_master.stop();
    bat_low = 1'h0;
    ticks(DAY - 1);
    check(8'(flag), 8'h01);
    ticks(1);
    check(8'(flag), 8'h00);
    // supply failure in mid-read, battery backup, recovery
    point(6'h00, 1'h1);
    pfail = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    check(8'(rst_oe), 8'h01);
    check(8'(hold), 8'h00);
    i_master.stop();
    i_master.start();
    i_master.xbyte({8'hD0, 1'h1}, r);
    check(8'(r[0]), 8'h01);
    i_master.stop();
    bat_low = 1'h1;
    ticks(DAY);
    check(8'(flag), 8'h00);
    on_bat = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    check({7'h00, rst_oe | sda_oe}, 8'h00);
    on_bat = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    check(8'(rst_oe), 8'h01);
    pfail = 1'h0;
    wait_rst();
    check(8'(flag), 8'h01);
    i_master.start();
    send(8'hD1);
    get(1'h0);
    check(r[8:1], 8'h22);
    i_master.stop();
    results();
  end
endmodule

`default_nettype wire

/* File: verif/rtcsa_master.sv */
`timescale 1ns/10ps
`default_nettype none

// ============================================================
// bit-banged bus master standing in for the host controller
module rtcsa_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_pull
);
  int slow = 0;  // extra cycles per quarter bit, to stretch the bus clock

  // idle bus: both lines released high
  initial
  begin
    o_scl = 1'h1;
    o_sda_pull = 1'h0;
  end

  // quarter bit of 16 ns, so a bit takes one 64 ns bus clock
  task automatic q();
    repeat (4 + slow) @(posedge i_clk);
    #1;
  endtask

  // start, also the repeated start before a read
  task automatic start();
    o_sda_pull = 1'h0;
    q();
    o_scl = 1'h1;
    q();
    o_sda_pull = 1'h1;
    q();
    o_scl = 1'h0;
    q();
  endtask

  // stop: data is released while the bus clock is high
  task automatic stop();
    o_sda_pull = 1'h1;
    q();
    o_scl = 1'h1;
    q();
    o_sda_pull = 1'h0;
    q();
  endtask

  task automatic xfer(input logic b, output logic r);
    o_sda_pull = !b;
    q();
    o_scl = 1'h1;
    q();
    r = i_sda;
    q();
    o_scl = 1'h0;
    q();
  endtask

  // eight bits msb first plus the ack bit; a read sends ones and its own ack
  task automatic xbyte(input logic [8:0] o, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
      xfer(o[i], r[i]);
  endtask
endmodule

`default_nettype wire
